// ===== rtl/uart_core.sv
// Serial port with four modes, receive buffer and baud-rate generator.
// Assumes a classic Wishbone master on clk_i and a Timer 1 overflow pulse on the same clock.
// Notes on behaviour
// - Transmitter and receiver run independently and may work at the same time in modes 1 to 3.
// - Reception may start while a byte is unread; completing then loses the new byte.
// - Frames carry 8 or 9 data bits, least significant bit first.
// - Mode 0 shift register, 1 8-bit variable, 2 9-bit fixed, 3 9-bit variable.
// - Mode 0 shifts one bit every two clocks.
// - Mode 2 bit rate is clock divided by 32 or 64, selectable.
// - Variable modes use baud timer underflows or Timer 1 overflows.
// - Baud timer counts down on fractional output if enabled, else prescaler output.
// - With divider mode select 0 the run bit starts and stops the timer.
// - Each underflow reloads the 8-bit reload value and emits one pulse.
// - Enabled divider in normal mode stops the timer; run bit ignored.
// - Prescaler divides clock by two to the power of prescale select.
// - Fractional divider scales by step/256 only when enabled in fractional mode.
// - Without fraction, rate is clock/(16*prescale*(reload+1)); product must exceed one.
// - Generated bit rate reaches clock divided by 16 when that product is one.
// - Interrupt raised when a frame transmission or reception completes.
// - In modes 1 to 3 serial data goes out on the transmit line and comes in on receive; mode 0 uses the receive line both ways.
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module uart_core
  import uart_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        t1_ovf_i,
  input  wire logic        rxd_i,
  output logic             rxd_o,
  output logic             rxd_oe_o,
  output logic             txd_o,
  output logic             irq_o
);

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_STOP  = 3'b011,
    TX_SHIFT = 3'b100
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

  logic            ack_r;
  logic            wr_fire;
  logic            rd_fire;
  logic [1:0]      mode_r;
  logic            rx_en_r;
  logic            m2_fast_r;
  logic            use_t1_r;
  logic            run_r;
  logic [2:0]      presc_r;
  logic [7:0]      reload_r;
  logic            fd_en_r;
  logic            fd_mode_r;
  logic [7:0]      step_r;
  logic [2:0]      irq_stat_r;
  logic [2:0]      irq_mask_r;
  logic [2:0]      irq_set;
  logic [6:0]      pre_cnt_r;
  logic [6:0]      pre_last;
  logic            pre_tick;
  logic [7:0]      acc_r;
  logic [8:0]      acc_sum;
  logic            frac_tick;
  logic            timer_clk;
  logic            timer_on;
  logic [7:0]      btm_r;
  logic            baud_pulse_r;
  logic [1:0]      m2_cnt_r;
  logic            ovs_tick;
  logic            rxd_meta_r;
  logic            rxd_s_r;
  logic            nine_bits;
  logic [3:0]      bits_last;
  tx_state_t       tx_st_r;
  logic [3:0]      tx_sub_r;
  logic [3:0]      tx_bit_r;
  logic [8:0]      tx_sh_r;
  logic [8:0]      tx_last_r;
  logic            tx_line_r;
  logic            m0_rx_r;
  logic            m0_clk_r;
  logic            tx_done;
  logic            m0_done;
  logic            tx_start_req;
  logic            m0_rx_req;
  rx_state_t       rx_st_r;
  logic [3:0]      rx_sub_r;
  logic [3:0]      rx_bit_r;
  logic [8:0]      rx_sh_r;
  logic [8:0]      rx_buf_r;
  logic            rx_full_r;
  logic            rx_done;
  logic            rx_lost;
  logic [31:0]     rd_data;

  // Bus slave: ack one cycle after the request, effects at the ack edge
  assign wr_fire = cyc_i & stb_i & ack_r & we_i;
  assign rd_fire = cyc_i & stb_i & ack_r & ~we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= cyc_i & stb_i & ~ack_r;
    end
  end
  assign ack_o = ack_r;

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (adr_i)
      OFS_SER_CTRL:  rd_data[4:0] = {use_t1_r, m2_fast_r, rx_en_r, mode_r};
      OFS_TX_DATA:   rd_data[8:0] = tx_last_r;
      OFS_RX_DATA:   rd_data[8:0] = rx_buf_r;
      OFS_BAUD_CTRL: rd_data[3:0] = {presc_r, run_r};
      OFS_BAUD_RLD:  rd_data[7:0] = reload_r;
      OFS_FRAC_CTRL: rd_data[1:0] = {fd_mode_r, fd_en_r};
      OFS_FRAC_STEP: rd_data[7:0] = step_r;
      OFS_IRQ_STAT:  rd_data[2:0] = irq_stat_r;
      OFS_IRQ_MASK:  rd_data[2:0] = irq_mask_r;
      OFS_STATUS:    rd_data[2:0] = {rx_full_r, rx_st_r != RX_IDLE, tx_st_r != TX_IDLE};
      default:       rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (cyc_i & stb_i & ~ack_r) begin
      dat_o <= rd_data;
    end
  end

  // Configuration registers; only byte lane 0 carries fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {use_t1_r, m2_fast_r, rx_en_r, mode_r} <= SER_CTRL_RST[4:0];
      run_r     <= 1'b0;
      presc_r   <= 3'b000;
      reload_r  <= BAUD_RLD_RST;
      fd_en_r   <= 1'b0;
      fd_mode_r <= 1'b0;
      step_r    <= FRAC_STEP_RST;
      irq_mask_r <= IRQ_RST;
    end else if (wr_fire && sel_i[0]) begin
      unique case (adr_i)
        OFS_SER_CTRL: begin
          mode_r    <= dat_i[SC_MODE_LSB +: 2];
          rx_en_r   <= dat_i[SC_RX_EN];
          m2_fast_r <= dat_i[SC_M2_FAST];
          use_t1_r  <= dat_i[SC_USE_T1];
        end
        OFS_BAUD_CTRL: begin
          run_r   <= dat_i[BC_RUN];
          presc_r <= dat_i[BC_PRE_LSB +: 3];
        end
        OFS_BAUD_RLD:  reload_r <= dat_i[7:0];
        OFS_FRAC_CTRL: begin
          fd_en_r   <= dat_i[FC_EN];
          fd_mode_r <= dat_i[FC_MODE_SEL];
        end
        OFS_FRAC_STEP: step_r <= dat_i[7:0];
        OFS_IRQ_MASK:  irq_mask_r <= dat_i[2:0];
        default: ;
      endcase
    end
  end

  // Prescaler: one tick every 2^presc clocks
  assign pre_last = 7'((8'd1 << presc_r) - 8'd1);
  assign pre_tick = (pre_cnt_r == pre_last);

  always_ff @(posedge clk_i) begin
    if (rst_i || pre_tick) begin
      pre_cnt_r <= 7'h00;
    end else begin
      pre_cnt_r <= pre_cnt_r + 7'h01;
    end
  end

  // Fractional divider: carry of a step accumulator gives step/256 of ticks
  assign acc_sum   = {1'b0, acc_r} + {1'b0, step_r};
  assign frac_tick = pre_tick & acc_sum[8];

  always_ff @(posedge clk_i) begin
    if (rst_i || !fd_en_r || fd_mode_r) begin
      acc_r <= 8'h00;
    end else if (pre_tick) begin
      acc_r <= acc_sum[7:0];
    end
  end

  // Baud timer: counts down, reload and pulse on underflow
  assign timer_clk = fd_en_r ? frac_tick : pre_tick;
  assign timer_on  = run_r & ~(fd_en_r & fd_mode_r);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      btm_r        <= 8'h00;
      baud_pulse_r <= 1'b0;
    end else begin
      baud_pulse_r <= 1'b0;
      if (!timer_on) begin
        btm_r <= reload_r;
      end else if (timer_clk) begin
        if (btm_r == 8'h00) begin
          btm_r        <= reload_r;
          baud_pulse_r <= 1'b1;
        end else begin
          btm_r <= btm_r - 8'h01;
        end
      end
    end
  end

  // Mode 2 fixed-rate tick at 16 per bit
  always_ff @(posedge clk_i) begin
    if (rst_i || ovs_tick && mode_r == MODE_9_FIX) begin
      m2_cnt_r <= 2'h0;
    end else begin
      m2_cnt_r <= m2_cnt_r + 2'h1;
    end
  end

  // Sixteen ticks per bit; a reload product of one would exceed clock/32
  always_comb begin
    if (mode_r == MODE_9_FIX) begin
      ovs_tick = (m2_cnt_r == (m2_fast_r ? M2_DIV32_LAST : M2_DIV64_LAST));
    end else begin
      ovs_tick = use_t1_r ? t1_ovf_i : baud_pulse_r;
    end
  end

  assign nine_bits = mode_r[1];
  assign bits_last = nine_bits ? BITS9_LAST : BITS8_LAST;

  // Receive pin synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxd_meta_r <= 1'b1;
      rxd_s_r    <= 1'b1;
    end else begin
      rxd_meta_r <= rxd_i;
      rxd_s_r    <= rxd_meta_r;
    end
  end

  // Transmitter, also runs the mode 0 shift register in both directions
  assign tx_start_req = wr_fire && sel_i[0] && adr_i == OFS_TX_DATA;
  assign m0_rx_req    = wr_fire && sel_i[0] && adr_i == OFS_SER_CTRL &&
                        dat_i[SC_MODE_LSB +: 2] == MODE_SHIFT && dat_i[SC_RX_EN] &&
                        dat_i[SC_M0_RX_GO];
  assign tx_done = (tx_st_r == TX_STOP) && ovs_tick && tx_sub_r == OVS_LAST;
  assign m0_done = (tx_st_r == TX_SHIFT) && m0_clk_r && tx_bit_r == BITS8_LAST;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_last_r <= 9'h000;
    end else if (tx_start_req) begin
      tx_last_r <= dat_i[8:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st_r   <= TX_IDLE;
      tx_sub_r  <= 4'h0;
      tx_bit_r  <= 4'h0;
      tx_sh_r   <= 9'h1FF;
      tx_line_r <= 1'b1;
      m0_rx_r   <= 1'b0;
      m0_clk_r  <= 1'b1;
    end else begin
      unique case (tx_st_r)
        TX_IDLE: begin
          tx_line_r <= 1'b1;
          m0_clk_r  <= 1'b1;
          tx_sub_r  <= 4'h0;
          tx_bit_r  <= 4'h0;
          if (tx_start_req || m0_rx_req) begin
            tx_sh_r <= tx_start_req ? dat_i[8:0] : 9'h1FF;
            m0_rx_r <= m0_rx_req;
            if (mode_r == MODE_SHIFT || m0_rx_req) begin
              tx_st_r  <= TX_SHIFT;
              m0_clk_r <= 1'b0;
            end else begin
              tx_st_r <= TX_START;
            end
          end
        end
        TX_SHIFT: begin
          // Clock low: present data; clock high: sample, one bit per 2 clocks
          m0_clk_r <= ~m0_clk_r;
          if (m0_clk_r) begin
            if (m0_rx_r) begin
              tx_sh_r[tx_bit_r] <= rxd_s_r;
            end
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_bit_r == BITS8_LAST) begin
              tx_st_r  <= TX_IDLE;
              m0_clk_r <= 1'b1;
            end
          end
        end
        TX_START, TX_DATA, TX_STOP: begin
          if (ovs_tick && tx_st_r == TX_START && tx_line_r) begin
            // Start bit opens on a tick, else it falls short of 16 ticks
            tx_line_r <= 1'b0;
          end else if (ovs_tick) begin
            tx_sub_r <= tx_sub_r + 4'h1;
            if (tx_sub_r == OVS_LAST) begin
              unique case (tx_st_r)
                TX_START: begin
                  tx_st_r   <= TX_DATA;
                  tx_line_r <= tx_sh_r[0];
                  tx_sh_r   <= {1'b1, tx_sh_r[8:1]};
                end
                TX_DATA: begin
                  tx_bit_r <= tx_bit_r + 4'h1;
                  if (tx_bit_r == bits_last) begin
                    tx_st_r   <= TX_STOP;
                    tx_line_r <= 1'b1;
                  end else begin
                    tx_line_r <= tx_sh_r[0];
                    tx_sh_r   <= {1'b1, tx_sh_r[8:1]};
                  end
                end
                default: tx_st_r <= TX_IDLE;
              endcase
            end
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // Mode 0: data on the receive pin, shift clock on the transmit pin
  assign txd_o    = (mode_r == MODE_SHIFT) ? m0_clk_r : tx_line_r;
  assign rxd_oe_o = (tx_st_r == TX_SHIFT) && !m0_rx_r;
  assign rxd_o    = tx_sh_r[tx_bit_r];

  // Receiver, independent of the transmitter except in mode 0, where the transmitter runs reception
  assign rx_done = ((rx_st_r == RX_STOP) && ovs_tick && rx_sub_r == OVS_MID) ||
                   (m0_done && m0_rx_r);
  assign rx_lost = rx_done & rx_full_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_st_r  <= RX_IDLE;
      rx_sub_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_sh_r  <= 9'h000;
    end else if (ovs_tick && mode_r != MODE_SHIFT) begin
      rx_sub_r <= rx_sub_r + 4'h1;
      unique case (rx_st_r)
        RX_IDLE: begin
          rx_sub_r <= 4'h0;
          rx_bit_r <= 4'h0;
          if (rx_en_r && !rxd_s_r) begin
            rx_st_r <= RX_START;
          end
        end
        RX_START: begin
          if (rx_sub_r == OVS_MID && rxd_s_r) begin
            rx_st_r <= RX_IDLE;
          end else if (rx_sub_r == OVS_LAST) begin
            rx_st_r <= RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_sub_r == OVS_MID) begin
            rx_sh_r[rx_bit_r] <= rxd_s_r;
          end else if (rx_sub_r == OVS_LAST) begin
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == bits_last) begin
              rx_st_r <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          // Finish mid stop bit so a back-to-back start edge is seen
          if (rx_sub_r == OVS_MID) begin
            rx_st_r <= RX_IDLE;
          end
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // Receive buffer: newer byte is dropped if the older one is unread
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_buf_r  <= 9'h000;
      rx_full_r <= 1'b0;
    end else begin
      if (rx_done && !rx_full_r) begin
        rx_buf_r  <= m0_rx_r ? {1'b0, tx_sh_r[7:0]} :
                     (nine_bits ? rx_sh_r : {1'b0, rx_sh_r[7:0]});
        rx_full_r <= 1'b1;
      end else if (rd_fire && adr_i == OFS_RX_DATA) begin
        rx_full_r <= 1'b0;
      end
    end
  end

  // Sticky interrupt status, write one to clear; a new event wins
  assign irq_set = {rx_lost, rx_done & ~rx_full_r, tx_done | (m0_done & ~m0_rx_r)};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= IRQ_RST;
    end else if (wr_fire && sel_i[0] && adr_i == OFS_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~dat_i[2:0]) | irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

endmodule
`default_nettype wire

// ===== rtl/uart_pkg.sv
// Shared constants for the serial port with its baud-rate generator.
// Assumes a 32-bit classic Wishbone register bus with word-aligned byte addresses.
package uart_pkg;

  localparam int unsigned CLK_HZ        = 50_000_000;

  // Register byte offsets
  localparam logic [7:0]  OFS_SER_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_TX_DATA   = 8'h04;
  localparam logic [7:0]  OFS_RX_DATA   = 8'h08;
  localparam logic [7:0]  OFS_BAUD_CTRL = 8'h0C;
  localparam logic [7:0]  OFS_BAUD_RLD  = 8'h10;
  localparam logic [7:0]  OFS_FRAC_CTRL = 8'h14;
  localparam logic [7:0]  OFS_FRAC_STEP = 8'h18;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h1C;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h20;
  localparam logic [7:0]  OFS_STATUS    = 8'h24;

  // Serial control fields
  localparam int unsigned SC_MODE_LSB   = 0;
  localparam int unsigned SC_RX_EN      = 2;
  localparam int unsigned SC_M2_FAST    = 3;
  localparam int unsigned SC_USE_T1     = 4;
  localparam int unsigned SC_M0_RX_GO   = 5;

  // Baud control fields
  localparam int unsigned BC_RUN        = 0;
  localparam int unsigned BC_PRE_LSB    = 1;

  // Fractional divider control fields
  localparam int unsigned FC_EN         = 0;
  localparam int unsigned FC_MODE_SEL   = 1;

  // Interrupt / status bits
  localparam int unsigned IRQ_TX_DONE   = 0;
  localparam int unsigned IRQ_RX_DONE   = 1;
  localparam int unsigned IRQ_OVERRUN   = 2;
  localparam int unsigned ST_TX_BUSY    = 0;
  localparam int unsigned ST_RX_BUSY    = 1;
  localparam int unsigned ST_RX_FULL    = 2;

  // Reset values
  localparam logic [5:0]  SER_CTRL_RST  = 6'h00;
  localparam logic [7:0]  BAUD_RLD_RST  = 8'h00;
  localparam logic [7:0]  FRAC_STEP_RST = 8'h00;
  localparam logic [2:0]  IRQ_RST       = 3'h0;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_8_VAR = 2'b01,
    MODE_9_FIX = 2'b10,
    MODE_9_VAR = 2'b11
  } ser_mode_t;

  // Timing: 16 oversample ticks per bit; mode 2 tick every 2 or 4 clocks
  localparam logic [3:0]  OVS_LAST      = 4'hF;
  localparam logic [3:0]  OVS_MID       = 4'h7;
  localparam logic [1:0]  M2_DIV32_LAST = 2'h1;
  localparam logic [1:0]  M2_DIV64_LAST = 2'h3;
  localparam logic [3:0]  BITS8_LAST    = 4'h7;
  localparam logic [3:0]  BITS9_LAST    = 4'h8;

endpackage

// ===== tb/uart_core_sva.sv
// Checker for bus handshake, reset state and serial line timing of uart_core.
// Sees only the ports of uart_core; attached by the bind at the foot.
`timescale 1ns/1ns
`default_nettype none
module uart_core_sva
  import uart_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        t1_ovf_i,
  input wire logic        rxd_i,
  input wire logic        rxd_o,
  input wire logic        rxd_oe_o,
  input wire logic        txd_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Cycles since the line last changed; saturates so idle time never wraps
  logic [7:0] run_r;
  always_ff @(posedge clk_i) begin
    if (rst_i)
      run_r <= 8'hFF;
    else if ($changed(txd_o))
      run_r <= 8'h00;
    else if (run_r != 8'hFF)
      run_r <= run_r + 8'h01;
  end
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged in the next cycle");
  a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  a_reset_state: assert property ($fell(rst_i) |-> !ack_o && !irq_o && !rxd_oe_o && txd_o
    && dat_o == 32'h0000_0000)
    else $error("outputs not idle after reset");
  a_shift_low_half: assert property (rxd_oe_o && !txd_o |=> txd_o)
    else $error("shift clock low for more than one cycle");
  a_shift_high_half: assert property (rxd_oe_o && txd_o && $past(rxd_oe_o)
    |=> !txd_o || !rxd_oe_o)
    else $error("shift clock high for more than one cycle");
  a_shift_data_hold: assert property (rxd_oe_o && $past(rxd_oe_o) && !$fell(txd_o)
    |-> $stable(rxd_o))
    else $error("shift data moved off the falling shift clock");
  a_bit_min_len: assert property ($changed(txd_o) && !rxd_oe_o && !$past(rxd_oe_o)
    && !$past(rxd_oe_o, 2) |-> run_r >= 8'h1F)
    else $error("serial bit shorter than 32 clocks");
endmodule
bind uart_core uart_core_sva i_sva (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .t1_ovf_i(t1_ovf_i),
  .rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .irq_o(irq_o)
);
`default_nettype wire

// ===== tb/serial_node.sv
// Remote asynchronous node: decodes frames on the line and sends frames back.
// Bit length in clocks and data bit count are set by the bench.
`timescale 1ns/1ns
`default_nettype none
module serial_node (
  input  wire logic       clk_i,
  input  wire logic       txd_i,
  input  wire logic       listen_i,
  input  wire logic [9:0] bitc_i,
  input  wire logic [3:0] nbits_i,
  output logic            rxd_o
);
  logic [8:0] got;
  logic       got_stop;
  int         got_n = 0;
  initial rxd_o = 1'b1;
  // Sample each bit in its middle; start seen on the falling line
  always @(negedge txd_i) begin
    if (listen_i) begin
      repeat (bitc_i / 2) @(posedge clk_i);
      got = 9'h000;
      for (int i = 0; i < nbits_i; i++) begin
        repeat (bitc_i) @(posedge clk_i);
        got[i] = txd_i;
      end
      repeat (bitc_i) @(posedge clk_i);
      got_stop = txd_i;
      got_n++;
    end
  end
  task send(input logic [8:0] w);
    @(posedge clk_i);
    rxd_o <= 1'b0;
    repeat (bitc_i) @(posedge clk_i);
    for (int i = 0; i < nbits_i; i++) begin
      rxd_o <= w[i];
      repeat (bitc_i) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
    repeat (bitc_i) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for uart_core over classic Wishbone.
// Assumes serial_node on the line and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import uart_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic        t1_on = 1'b0;
  logic        t1_ovf = 1'b0;
  logic        listen = 1'b0;
  logic [9:0]  bitc = 10'h020;
  logic [3:0]  nbits = 4'h8;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        rxd_o;
  logic        rxd_oe_o;
  logic        txd_o;
  logic        irq_o;
  wire logic   node_rxd;
  // Shared pin: the device wins while it drives in shift mode
  wire logic   rxd_pin = rxd_oe_o ? rxd_o : node_rxd;
  int          failures = 0;
  int          total_checks = 0;
  always #10 clk_i = ~clk_i;
  // Overflow pulse every two clocks gives 32-clock bits
  always @(posedge clk_i) t1_ovf <= t1_on && !t1_ovf;
  uart_core i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .t1_ovf_i(t1_ovf),
    .rxd_i(rxd_pin), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .irq_o(irq_o));
  serial_node i_node (.clk_i(clk_i), .txd_i(txd_o), .listen_i(listen), .bitc_i(bitc),
    .nbits_i(nbits), .rxd_o(node_rxd));
  task complete_run;
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task give_up;
    failures++;
    complete_run;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50)
      give_up;
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] q);
    bus(a, 1'b0, 32'h0000_0000, q);
  endtask
  task poll(input logic [31:0] m);
    int n;
    logic [31:0] q;
    n = 0;
    do begin
      rd(OFS_IRQ_STAT, q);
      n++;
    end while ((q & m) !== m && n < 3000);
    if (n >= 3000)
      give_up;
  endtask
  task frame(input logic [31:0] ser, input int bc, input int nb, input logic [8:0] tw,
             input logic [8:0] rw);
    int g;
    logic [31:0] q;
    g = i_node.got_n;
    bitc = 10'(bc);
    nbits = 4'(nb);
    listen = 1'b1;
    wr(OFS_SER_CTRL, ser);
    fork
      wr(OFS_TX_DATA, {23'h0, tw});
      i_node.send(rw);
    join
    poll(32'h0000_0003);
    chk("tx word", {23'h0, tw}, {23'h0, i_node.got});
    chk("tx stop", 32'h0000_0001, {31'h0, i_node.got_stop});
    chk("tx frames", 32'(g + 1), 32'(i_node.got_n));
    rd(OFS_RX_DATA, q);
    chk("rx word", {23'h0, rw}, q & (nb == 9 ? 32'h0000_01FF : 32'h0000_00FF));
    wr(OFS_IRQ_STAT, 32'h0000_0007);
    @(negedge clk_i);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq_o});
    $display("Test frame mode %h bit %0d done", ser, bc);
  endtask
  initial begin
    logic [31:0] q;
    logic [7:0]  sh;
    int          n;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_IRQ_MASK, q);
    chk("mask reset", 32'h0000_0000, q);
    rd(OFS_STATUS, q);
    chk("status reset", 32'h0000_0000, q);
    rd(8'h3C, q);
    chk("unmapped", 32'h0000_0000, q);
    wr(OFS_IRQ_MASK, 32'h0000_0003);
    wr(OFS_BAUD_RLD, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_BAUD_CTRL, 32'((i << 1) | 1));
      frame(32'h0000_0005, 32 << i, 8, 9'h0A4 + 9'(i), 9'h03C);
    end
    wr(OFS_BAUD_CTRL, 32'h0000_0001);
    frame(32'h0000_0007, 32, 9, 9'h13C, 9'h1C3);
    frame(32'h0000_000E, 32, 9, 9'h0F0, 9'h10F);
    frame(32'h0000_0006, 64, 9, 9'h155, 9'h0AA);
    t1_on <= 1'b1;
    frame(32'h0000_0015, 32, 8, 9'h066, 9'h099);
    t1_on <= 1'b0;
    // Step of 128 halves the rate, a fast setting for the fraction
    wr(OFS_FRAC_STEP, 32'h0000_0080);
    wr(OFS_FRAC_CTRL, 32'h0000_0001);
    frame(32'h0000_0005, 64, 8, 9'h0E1, 9'h01E);
    wr(OFS_FRAC_CTRL, 32'h0000_0000);
    bitc = 10'h020;
    for (int i = 0; i < 2; i++) begin
      if (i == 0)
        wr(OFS_BAUD_CTRL, 32'h0000_0000);
      else
        wr(OFS_FRAC_CTRL, 32'h0000_0003);
      wr(OFS_TX_DATA, 32'h0000_00C3);
      n = 0;
      repeat (300) begin
        @(negedge clk_i);
        if (txd_o !== 1'b1)
          n++;
      end
      chk("line held", 32'h0000_0000, 32'(n));
      wr(OFS_BAUD_CTRL, 32'h0000_0001);
      wr(OFS_FRAC_CTRL, 32'h0000_0000);
      poll(32'h0000_0001);
      chk("resumed word", 32'h0000_00C3, {23'h0, i_node.got});
      wr(OFS_IRQ_STAT, 32'h0000_0007);
    end
    $display("Test timer stop done");
    i_node.send(9'h011);
    i_node.send(9'h022);
    poll(32'h0000_0006);
    rd(OFS_RX_DATA, q);
    chk("kept byte", 32'h0000_0011, q & 32'h0000_00FF);
    wr(OFS_IRQ_STAT, 32'h0000_0007);
    $display("Test overrun done");
    listen = 1'b0;
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    wr(OFS_SER_CTRL, 32'h0000_0000);
    wr(OFS_TX_DATA, 32'h0000_0096);
    for (int i = 0; i < 8; i++) begin
      n = 0;
      do begin
        @(negedge clk_i);
        n++;
      end while (!(rxd_oe_o === 1'b1 && txd_o === 1'b0) && n < 50);
      if (n >= 50)
        give_up;
      sh[i] = rxd_o;
    end
    chk("shift out", 32'h0000_0096, {24'h0, sh});
    poll(32'h0000_0001);
    chk("irq masked", 32'h0000_0000, {31'h0, irq_o});
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    @(negedge clk_i);
    chk("irq unmasked", 32'h0000_0001, {31'h0, irq_o});
    wr(OFS_IRQ_STAT, 32'h0000_0001);
    @(negedge clk_i);
    chk("irq w1c", 32'h0000_0000, {31'h0, irq_o});
    $display("Test shift mode done");
    complete_run;
  end
endmodule
`default_nettype wire
